// >>> design/sdcd_burst_ctr.sv
// burst length counter: busy while a started burst runs
`timescale 1ns/100ps
`include "sdcd_consts.svh"
module sdcd_burst_ctr #(
	parameter int CW = `SDCD_CNT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [CW-1:0] len,
	output logic busy,
	output logic free
);
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic busy_d;

	always_comb begin
		count_d = count_q;
		if (load) begin
			count_d = len;
		end else if (count_q != '0) begin
			count_d = count_q - 1'b1;
		end
		busy_d = (count_d != '0);
		// a new burst may start when none runs or in the last cycle of the running one
		free = (count_q <= {{(CW-1){1'b0}}, 1'b1});
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
			busy <= 1'b0;
		end else begin
			count_q <= count_d;
			busy <= busy_d;
		end
	end
endmodule : sdcd_burst_ctr

// >>> design/sdcd_consts.svh
// bit positions and burst timing counts of the command decoder
`ifndef SDCD_CONSTS_SVH
`define SDCD_CONSTS_SVH
`define SDCD_AUTO_CLOSE_BIT 10
`define SDCD_BURST_CHOP_BIT 12
`define SDCD_RESERVED_BIT 13
`define SDCD_EIGHT_CLKS 3'h4
`define SDCD_FOUR_CLKS 3'h2
`define SDCD_CNT_W 3
`endif

// >>> design/sdcd_decoder.sv
// command decoder: samples strobes each edge and reports the decoded command
`timescale 1ns/100ps
`include "sdcd_consts.svh"
// Function
// - decode strobes and clock gate every edge
// - group lines pick bank or mode register
// - row open command opens given row
// - store decode, column address, programmed length
// - fetch decode, column address, programmed length
// - auto close bit closes bank after burst
// - on the fly, chop bit low: four
// - on the fly, chop bit high: eight
// - running burst cannot be cut short
// - idle command leaves running burst alone
// - chip select high means deselect, like idle
// - clock gate edges enter, leave low power
// - refresh with gate falling enters sleep unless a burst is busy
// - termination ignored by decode, off asleep
module sdcd_decoder (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire sdcd_pkg::sdcd_pins_s CA_PINS,
	input wire logic TERMINATION_CONTROL,
	input wire logic BURST_ON_THE_FLY,
	input wire logic FIXED_CHOP_FOUR,
	output sdcd_pkg::sdcd_cmd_s CMD_OUT,
	output logic CMD_VALID,
	output logic BURST_REJECT,
	output logic BURST_BUSY,
	output logic LOW_POWER,
	output logic SLEEP_ACTIVE,
	output logic TERM_ACTIVE
);
	import sdcd_pkg::*;

	sdcd_pins_s p;
	sdcd_state_e st_q;
	sdcd_state_e st_d;
	sdcd_cmd_e code;
	sdcd_cmd_s cmd_d;
	logic chop;
	logic rej_d;
	logic load;
	logic burst_free;
	logic is_idle;
	logic is_ref;
	logic [`SDCD_CNT_W-1:0] len;
	logic vld_d;
	logic lowp_d;
	logic slp_d;
	logic term_d;

	assign p = CA_PINS;

	// idle or deselect qualify gate transitions
	assign is_idle = p.cs_n || (p.ras_n && p.cas_n && p.we_n);
	assign is_ref = !p.cs_n && !p.ras_n && !p.cas_n && p.we_n;

	assign chop = BURST_ON_THE_FLY ? !p.addr[`SDCD_BURST_CHOP_BIT] : FIXED_CHOP_FOUR;
	assign len = chop ? `SDCD_FOUR_CLKS : `SDCD_EIGHT_CLKS;

	always_comb begin
		st_d = st_q;
		code = SDCD_NONE;
		rej_d = 1'b0;
		load = 1'b0;
		case (st_q)
			SDCD_ST_SELFREF: begin
				if (p.cke) begin
					if (is_idle) begin
						code = SDCD_SLEEP_RESTORE_LEAVE;
						st_d = SDCD_ST_ACTIVE;
					end else begin
						code = SDCD_ILLEGAL;
					end
				end
			end
			SDCD_ST_PWRDN: begin
				if (p.cke) begin
					if (is_idle) begin
						code = SDCD_LOW_POWER_LEAVE;
						st_d = SDCD_ST_ACTIVE;
					end else begin
						code = SDCD_ILLEGAL;
					end
				end
			end
			SDCD_ST_ACTIVE: begin
				if (!p.cke) begin
					if (is_ref && !BURST_BUSY) begin
						code = SDCD_SLEEP_RESTORE_ENTER;
						st_d = SDCD_ST_SELFREF;
					end else if (is_idle) begin
						code = SDCD_LOW_POWER_ENTER;
						st_d = SDCD_ST_PWRDN;
					end else begin
						code = SDCD_ILLEGAL;
					end
				end else if (p.cs_n) begin
					code = SDCD_DESELECT;
				end else begin
					case ({p.ras_n, p.cas_n, p.we_n})
						3'h0: code = SDCD_MODE_REG_WRITE;
						3'h1: code = SDCD_REFRESH;
						3'h2: begin
							code = p.addr[`SDCD_AUTO_CLOSE_BIT] ? SDCD_ALL_ROWS_CLOSE
								: SDCD_BANK_CLOSE;
						end
						3'h3: code = SDCD_ROW_OPEN;
						3'h4, 3'h5: begin
							if (burst_free) begin
								code = p.we_n ? SDCD_FETCH : SDCD_STORE;
								load = 1'b1;
							end else begin
								rej_d = 1'b1;
							end
						end
						3'h6: begin
							code = p.addr[`SDCD_AUTO_CLOSE_BIT] ? SDCD_IMPEDANCE_CAL_LONG
								: SDCD_IMPEDANCE_CAL_SHORT;
						end
						3'h7: code = SDCD_IDLE;
						default: code = SDCD_ILLEGAL;
					endcase
				end
			end
			default: st_d = SDCD_ST_ACTIVE;
		endcase
		cmd_d.code = code;
		cmd_d.array_group_select = p.array_group_select;
		cmd_d.addr = p.addr;
		cmd_d.auto_close_bit = load && p.addr[`SDCD_AUTO_CLOSE_BIT];
		cmd_d.chop_four = load && chop;
		vld_d = (code != SDCD_NONE);
		lowp_d = (st_d == SDCD_ST_PWRDN);
		slp_d = (st_d == SDCD_ST_SELFREF);
		term_d = TERMINATION_CONTROL && !slp_d;
	end

	sdcd_burst_ctr #(
		.CW(`SDCD_CNT_W)
	) u_burst (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.load(load),
		.len(len),
		.busy(BURST_BUSY),
		.free(burst_free)
	);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= SDCD_ST_ACTIVE;
			CMD_OUT <= '0;
			CMD_VALID <= 1'b0;
			BURST_REJECT <= 1'b0;
			LOW_POWER <= 1'b0;
			SLEEP_ACTIVE <= 1'b0;
			TERM_ACTIVE <= 1'b0;
		end else begin
			st_q <= st_d;
			CMD_OUT <= cmd_d;
			CMD_VALID <= vld_d;
			BURST_REJECT <= rej_d;
			LOW_POWER <= lowp_d;
			SLEEP_ACTIVE <= slp_d;
			TERM_ACTIVE <= term_d;
		end
	end

	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);

	logic sel_w;
	assign sel_w = (st_q == SDCD_ST_ACTIVE) && p.cke && !p.cs_n;

	mode_write_a: assert property (sel_w && !p.ras_n && !p.cas_n && !p.we_n |=>
		CMD_OUT.code == SDCD_MODE_REG_WRITE && CMD_OUT.addr == $past(p.addr)
		&& CMD_OUT.array_group_select == $past(p.array_group_select))
		else $error("mode write not decoded");
	row_open_a: assert property (sel_w && !p.ras_n && p.cas_n && p.we_n |=>
		CMD_OUT.code == SDCD_ROW_OPEN && CMD_VALID)
		else $error("row open not decoded");
	store_dec_a: assert property (sel_w && p.ras_n && !p.cas_n && !p.we_n && burst_free
		|=> CMD_OUT.code == SDCD_STORE ##1 BURST_BUSY)
		else $error("store not decoded");
	fetch_dec_a: assert property (sel_w && p.ras_n && !p.cas_n && p.we_n && burst_free
		|=> CMD_OUT.code == SDCD_FETCH
		&& CMD_OUT.auto_close_bit == $past(p.addr[`SDCD_AUTO_CLOSE_BIT]))
		else $error("fetch not decoded");
	chop_four_a: assert property (load && BURST_ON_THE_FLY
		&& !p.addr[`SDCD_BURST_CHOP_BIT]
		|=> CMD_OUT.chop_four ##0 BURST_BUSY[*2] ##1 (!BURST_BUSY || $past(load)))
		else $error("chop four length wrong");
	eight_beat_a: assert property (load && BURST_ON_THE_FLY
		&& p.addr[`SDCD_BURST_CHOP_BIT]
		|=> !CMD_OUT.chop_four ##0 BURST_BUSY[*4])
		else $error("eight beat length wrong");
	no_cut_a: assert property (BURST_BUSY && !burst_free |-> !load)
		else $error("burst cut short");
	deselect_a: assert property ((st_q == SDCD_ST_ACTIVE) && p.cke && p.cs_n |=>
		CMD_OUT.code == SDCD_DESELECT && ($stable(BURST_BUSY) || !BURST_BUSY))
		else $error("deselect not decoded");
	low_power_a: assert property ((st_q == SDCD_ST_ACTIVE) && !p.cke && p.cs_n |=>
		LOW_POWER && CMD_OUT.code == SDCD_LOW_POWER_ENTER)
		else $error("low power not entered");
	sleep_enter_a: assert property ((st_q == SDCD_ST_ACTIVE) && !p.cke && is_ref
		&& !BURST_BUSY |=> SLEEP_ACTIVE ##1 (SLEEP_ACTIVE || CMD_OUT.code
		== SDCD_SLEEP_RESTORE_LEAVE))
		else $error("sleep not entered");
	term_sleep_a: assert property (SLEEP_ACTIVE |-> !TERM_ACTIVE)
		else $error("termination on while asleep");
	refresh_dec_a: assert property (sel_w && !p.ras_n && !p.cas_n && p.we_n |=>
		CMD_OUT.code == SDCD_REFRESH)
		else $error("refresh not decoded");
	close_all_a: assert property (sel_w && !p.ras_n && p.cas_n && !p.we_n
		&& p.addr[`SDCD_AUTO_CLOSE_BIT] |=> CMD_OUT.code == SDCD_ALL_ROWS_CLOSE)
		else $error("close all not decoded");
	cal_long_a: assert property (sel_w && p.ras_n && p.cas_n && !p.we_n
		&& p.addr[`SDCD_AUTO_CLOSE_BIT] |=> CMD_OUT.code == SDCD_IMPEDANCE_CAL_LONG)
		else $error("long calibration not decoded");

	sleep_cycle_c: cover property (SLEEP_ACTIVE ##[1:20] CMD_OUT.code == SDCD_SLEEP_RESTORE_LEAVE);
	power_cycle_c: cover property (LOW_POWER ##[1:20] CMD_OUT.code == SDCD_LOW_POWER_LEAVE);
	back_burst_c: cover property (load ##4 load);
	reject_c: cover property (BURST_REJECT);
endmodule : sdcd_decoder

// >>> design/sdcd_pkg.sv
// types shared by the command decoder files
package sdcd_pkg;
	localparam int SDCD_GRP_W = 3;
	localparam int SDCD_ADDR_W = 14;

	typedef enum logic [15:0] {
		SDCD_NONE = 16'h0000,
		SDCD_MODE_REG_WRITE = 16'h0001,
		SDCD_REFRESH = 16'h0002,
		SDCD_SLEEP_RESTORE_ENTER = 16'h0004,
		SDCD_SLEEP_RESTORE_LEAVE = 16'h0008,
		SDCD_BANK_CLOSE = 16'h0010,
		SDCD_ALL_ROWS_CLOSE = 16'h0020,
		SDCD_ROW_OPEN = 16'h0040,
		SDCD_STORE = 16'h0080,
		SDCD_FETCH = 16'h0100,
		SDCD_IDLE = 16'h0200,
		SDCD_DESELECT = 16'h0400,
		SDCD_LOW_POWER_ENTER = 16'h0800,
		SDCD_LOW_POWER_LEAVE = 16'h1000,
		SDCD_IMPEDANCE_CAL_LONG = 16'h2000,
		SDCD_IMPEDANCE_CAL_SHORT = 16'h4000,
		SDCD_ILLEGAL = 16'h8000
	} sdcd_cmd_e;

	typedef enum logic [2:0] {
		SDCD_ST_ACTIVE = 3'h1,
		SDCD_ST_PWRDN = 3'h2,
		SDCD_ST_SELFREF = 3'h4
	} sdcd_state_e;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic [SDCD_GRP_W-1:0] array_group_select;
		logic [SDCD_ADDR_W-1:0] addr;
	} sdcd_pins_s;

	typedef struct packed {
		sdcd_cmd_e code;
		logic [SDCD_GRP_W-1:0] array_group_select;
		logic [SDCD_ADDR_W-1:0] addr;
		logic auto_close_bit;
		logic chop_four;
	} sdcd_cmd_s;
endpackage : sdcd_pkg

// >>> test/sdcd_ctl_model.sv
// controller model: drives the command pins for a requested command
`timescale 1ns/100ps
module sdcd_ctl_model (
	input wire logic clk,
	input wire sdcd_pkg::sdcd_cmd_e kind,
	input wire logic [2:0] grp,
	input wire logic [13:0] addr,
	output sdcd_pkg::sdcd_pins_s pins
);
	import sdcd_pkg::*;
	logic junk_q = 1'b0;
	logic [4:0] sc;
	always @(negedge clk) junk_q <= ~junk_q;
	always_comb begin
		// strobes then clock gate
		case (kind)
			SDCD_MODE_REG_WRITE: sc = 5'h01;
			SDCD_REFRESH: sc = 5'h03;
			SDCD_SLEEP_RESTORE_ENTER: sc = 5'h02;
			SDCD_BANK_CLOSE, SDCD_ALL_ROWS_CLOSE: sc = 5'h05;
			SDCD_ROW_OPEN: sc = 5'h07;
			SDCD_STORE: sc = 5'h09;
			SDCD_FETCH: sc = 5'h0b;
			SDCD_IMPEDANCE_CAL_LONG, SDCD_IMPEDANCE_CAL_SHORT: sc = 5'h0d;
			SDCD_DESELECT: sc = 5'h11;
			SDCD_LOW_POWER_ENTER: sc = 5'h10;
			SDCD_ILLEGAL: sc = 5'h08;
			default: sc = 5'h0f;
		endcase
		pins = {sc, grp, addr};
		if (kind inside {SDCD_ALL_ROWS_CLOSE, SDCD_IMPEDANCE_CAL_LONG})
			pins.addr[10] = 1'b1;
		if (kind inside {SDCD_BANK_CLOSE, SDCD_IMPEDANCE_CAL_SHORT})
			pins.addr[10] = 1'b0;
		if (sc[4]) begin
			{pins.ras_n, pins.cas_n, pins.we_n} = {3{junk_q}};
			pins.addr = {14{junk_q}};
		end
	end
endmodule : sdcd_ctl_model

// >>> test/tb.sv
// testbench: commands through the controller model, decoded results checked
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
$display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb;
	import sdcd_pkg::*;
	typedef struct packed {
		sdcd_cmd_e kind;
		logic [2:0] grp;
		logic [13:0] addr;
		logic ac;
		logic chop;
	} sdcd_row_s;
	logic REF_CLK = 1'b0;
	logic RSTN = 1'b0;
	logic otf = 1'b1;
	logic fix4 = 1'b0;
	logic term = 1'b1;
	sdcd_cmd_e kind = SDCD_IDLE;
	logic [2:0] grp = 3'h0;
	logic [13:0] addr = 14'h0000;
	sdcd_pins_s pins;
	sdcd_cmd_s cmd;
	logic vld, rej, busy, lowp, slp, tact;
	int err_total = 0;
	int n_checks = 0;
	sdcd_row_s rows [13];
	always #2.5 REF_CLK = ~REF_CLK;
	sdcd_ctl_model ctl (.clk(REF_CLK), .kind(kind), .grp(grp), .addr(addr), .pins(pins));
	sdcd_decoder dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .CA_PINS(pins),
		.TERMINATION_CONTROL(term), .BURST_ON_THE_FLY(otf), .FIXED_CHOP_FOUR(fix4),
		.CMD_OUT(cmd), .CMD_VALID(vld), .BURST_REJECT(rej), .BURST_BUSY(busy),
		.LOW_POWER(lowp), .SLEEP_ACTIVE(slp), .TERM_ACTIVE(tact));
	task automatic step(input sdcd_cmd_e k, input logic [13:0] a);
		kind = k;
		addr = a;
		@(negedge REF_CLK);
	endtask : step
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5000) @(posedge REF_CLK);
		`CHK("watchdog", 1'b0, 1'b1)
		complete_run();
	end
	initial begin
		rows = '{'{SDCD_MODE_REG_WRITE, 3'h2, 14'h0123, 1'b0, 1'b0},
			'{SDCD_ROW_OPEN, 3'h5, 14'h1abc, 1'b0, 1'b0},
			'{SDCD_FETCH, 3'h3, 14'h1404, 1'b1, 1'b0},
			'{SDCD_IDLE, 3'h0, 14'h0000, 1'b0, 1'b0},
			'{SDCD_REFRESH, 3'h0, 14'h0000, 1'b0, 1'b0},
			'{SDCD_BANK_CLOSE, 3'h1, 14'h0000, 1'b0, 1'b0},
			'{SDCD_STORE, 3'h6, 14'h0008, 1'b0, 1'b1},
			'{SDCD_ALL_ROWS_CLOSE, 3'h0, 14'h0000, 1'b0, 1'b0},
			'{SDCD_FETCH, 3'h4, 14'h0411, 1'b1, 1'b1},
			'{SDCD_DESELECT, 3'h0, 14'h0000, 1'b0, 1'b0},
			'{SDCD_STORE, 3'h7, 14'h1010, 1'b0, 1'b0},
			'{SDCD_IMPEDANCE_CAL_LONG, 3'h0, 14'h0000, 1'b0, 1'b0},
			'{SDCD_IMPEDANCE_CAL_SHORT, 3'h0, 14'h0000, 1'b0, 1'b0}};
		repeat (20) @(negedge REF_CLK);
		`CHK("rst code", SDCD_NONE, cmd.code)
		RSTN = 1'b1;
		foreach (rows[i]) begin
			grp = rows[i].grp;
			step(rows[i].kind, rows[i].addr);
			`CHK("code", rows[i].kind, cmd.code)
			`CHK("vld", 1'b1, vld)
			`CHK("close", rows[i].ac, cmd.auto_close_bit)
			`CHK("chop", rows[i].chop, cmd.chop_four)
			if (rows[i].kind inside {SDCD_MODE_REG_WRITE, SDCD_ROW_OPEN, SDCD_FETCH, SDCD_STORE}) begin
				`CHK("grp", rows[i].grp, cmd.array_group_select)
				`CHK("addr", rows[i].addr[9:0], cmd.addr[9:0])
			end
		end
		repeat (3) step(SDCD_IDLE, 14'h0000);
		step(SDCD_FETCH, 14'h1000);
		step(SDCD_IDLE, 14'h0000);
		step(SDCD_STORE, 14'h1000);
		`CHK("reject", 1'b1, rej)
		`CHK("rej code", SDCD_NONE, cmd.code)
		`CHK("rej vld", 1'b0, vld)
		step(SDCD_IDLE, 14'h0000);
		`CHK("busy", 1'b1, busy)
		step(SDCD_IDLE, 14'h0000);
		`CHK("busy end", 1'b0, busy)
		otf = 1'b0;
		fix4 = 1'b1;
		step(SDCD_FETCH, 14'h1000);
		`CHK("fixed", 1'b1, cmd.chop_four)
		repeat (2) step(SDCD_IDLE, 14'h0000);
		`CHK("chop end", 1'b0, busy)
		fix4 = 1'b0;
		step(SDCD_FETCH, 14'h0000);
		`CHK("fixed eight", 1'b0, cmd.chop_four)
		repeat (3) step(SDCD_IDLE, 14'h0000);
		`CHK("eight busy", 1'b1, busy)
		step(SDCD_IDLE, 14'h0000);
		`CHK("eight end", 1'b0, busy)
		otf = 1'b1;
		step(SDCD_LOW_POWER_ENTER, 14'h0000);
		`CHK("pd", 1'b1, lowp)
		step(SDCD_LOW_POWER_ENTER, 14'h0000);
		`CHK("pd hold", SDCD_NONE, cmd.code)
		step(SDCD_LOW_POWER_LEAVE, 14'h0000);
		`CHK("pd exit", SDCD_LOW_POWER_LEAVE, cmd.code)
		`CHK("pd off", 1'b0, lowp)
		step(SDCD_ILLEGAL, 14'h0000);
		`CHK("bad gate", SDCD_ILLEGAL, cmd.code)
		`CHK("bad gate pd", 1'b0, lowp)
		step(SDCD_FETCH, 14'h1000);
		step(SDCD_SLEEP_RESTORE_ENTER, 14'h0000);
		`CHK("sr busy", SDCD_ILLEGAL, cmd.code)
		`CHK("sr busy slp", 1'b0, slp)
		repeat (3) step(SDCD_IDLE, 14'h0000);
		step(SDCD_ALL_ROWS_CLOSE, 14'h0000);
		`CHK("term", 1'b1, tact)
		step(SDCD_SLEEP_RESTORE_ENTER, 14'h0000);
		`CHK("sr code", SDCD_SLEEP_RESTORE_ENTER, cmd.code)
		step(SDCD_SLEEP_RESTORE_ENTER, 14'h0000);
		`CHK("sr", 1'b1, slp)
		`CHK("sr term", 1'b0, tact)
		step(SDCD_SLEEP_RESTORE_LEAVE, 14'h0000);
		`CHK("srx", SDCD_SLEEP_RESTORE_LEAVE, cmd.code)
		term = 1'b0;
		step(SDCD_ROW_OPEN, 14'h0000);
		`CHK("term off", 1'b0, tact)
		`CHK("term code", SDCD_ROW_OPEN, cmd.code)
		term = 1'b1;
		repeat (512) step(SDCD_IDLE, 14'h0000);
		step(SDCD_FETCH, 14'h1000);
		#1 RSTN = 1'b0;
		#1 `CHK("rst busy", 1'b0, busy)
		`CHK("rst vld", 1'b0, vld)
		`CHK("rst lowp", 1'b0, lowp)
		@(negedge REF_CLK);
		RSTN = 1'b1;
		step(SDCD_IDLE, 14'h0000);
		`CHK("after rst", SDCD_IDLE, cmd.code)
		complete_run();
	end
endmodule : tb
